// file: src/mag_irq_pkg.sv
// Functional notes
// - Set axis positive flag above threshold
// - Set axis negative flag below negated threshold
// - Set range overflow flag on measurement overflow
// - Summary flag in bit zero on event
// - Threshold is unsigned magnitude, resets zero
// - One threshold applied to both signs
// - Threshold split over registers 32h and 33h
// - Threshold value resets to zero
// - Only enabled axes raise threshold events
// - Pin driven when enabled, selected polarity
// - Latched pin held until source read
// - Pin enable resets to zero
package mag_irq_pkg;
	// Register offsets on the serial register port
	localparam logic [7:0] cfg_addr = 8'h30;
	localparam logic [7:0] src_addr = 8'h31;
	localparam logic [7:0] ths_low_addr = 8'h32;
	localparam logic [7:0] ths_high_addr = 8'h33;
	// Configuration field positions
	localparam int x_ien_pos = 7;
	localparam int y_ien_pos = 6;
	localparam int z_ien_pos = 5;
	localparam int polarity_pos = 2;
	localparam int latch_pos = 1;
	localparam int pin_en_pos = 0;
	// Source field positions
	localparam int x_pos_pos = 7;
	localparam int x_neg_pos = 4;
	localparam int ovf_pos = 1;
	localparam int int_pos = 0;
	// Reset values
	localparam logic [7:0] cfg_reset = 8'h00;
	localparam logic [7:0] src_reset = 8'h00;
	localparam logic [7:0] ths_reset = 8'h00;
	localparam logic [7:0] rdata_reset = 8'h00;
	// Pin level at reset: inactive for the reset polarity, which is active low
	localparam logic irq_idle_reset = 1'b1;
	localparam logic [7:0] ths_high_mask = 8'h7f;
endpackage

// file: src/axis_compare.sv
`timescale 1ns/1ns
// One axis: signed sample against symmetric magnitude threshold
module axis_compare
	import mag_irq_pkg::*;
(
	input wire logic signed [15:0] sample,
	input wire logic [14:0] threshold_value,
	input wire logic axis_enable,
	output logic pos_hit,
	output logic neg_hit
);
	// Extend to 17 bits so negating the threshold never overflows
	logic signed [16:0] ext_sample;
	logic signed [16:0] pos_lim;
	logic signed [16:0] neg_lim;

	// Strict compare both sides, gated by axis enable
	always_comb
	begin
		ext_sample = {sample[15], sample};
		pos_lim = signed'({2'b00, threshold_value});
		neg_lim = -pos_lim;
		pos_hit = axis_enable && (ext_sample > pos_lim);
		neg_hit = axis_enable && (ext_sample < neg_lim);
	end
endmodule // axis_compare

// file: src/magnetic_threshold_interrupt.sv
`timescale 1ns/1ns
// Threshold interrupt generator with its four registers
module magnetic_threshold_interrupt
	import mag_irq_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic sample_valid,
	input wire logic [15:0] x_sample,
	input wire logic [15:0] y_sample,
	input wire logic [15:0] z_sample,
	input wire logic range_overflow,
	output logic irq_out,
	output logic irq_oe
);
	// Register state
	logic [7:0] cfg_reg; // Axis enables, polarity, latch control, pin enable
	logic [7:0] ths_low_reg; // Threshold bits 7..0
	logic [7:0] ths_high_reg; // Threshold bits 14..8, MSB kept zero
	logic [7:0] src_reg; // Source flags as the host reads them
	logic [7:0] src_next; // Source flags after the coming edge
	logic [7:0] rdata_next; // Read mux result for the coming edge
	logic irq_out_next; // Pin level after the coming edge

	// Comparator results; index 2 is X, 1 is Y, 0 is Z
	logic [2:0] pos_hit; // Sample above the positive threshold
	logic [2:0] neg_hit; // Sample below the negated threshold

	// Fields pulled out of the configuration and threshold registers
	logic [14:0] threshold_value; // Fifteen-bit unsigned magnitude
	logic [2:0] axis_en; // Per-axis enables, X in the top bit
	logic latched_mode; // Latch control low selects latching
	logic active_high; // Pin polarity, high means active high
	logic pin_enable; // Pin drive enable

	// Decoded bus strobes
	logic wr_cfg; // Write to the configuration register
	logic wr_ths_low; // Write to the low threshold byte
	logic wr_ths_high; // Write to the high threshold byte
	logic src_read; // Read of the source register

	// Event qualifiers
	logic axis_event; // Any enabled axis crossed the threshold
	logic event_now; // Any event, overflow included, on a valid sample

	// Address compare shared by all strobe decodes
	function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
		addr_is = (addr == target);
	endfunction

	// Apply the selected polarity to an internal active-high level
	function automatic logic to_pin(input logic level, input logic high_active);
		to_pin = high_active ? level : ~level;
	endfunction

	// Threshold is split over two bytes; the high MSB is not part of it
	assign threshold_value = {ths_high_reg[6:0], ths_low_reg};

	// Configuration fields
	assign axis_en = {cfg_reg[x_ien_pos], cfg_reg[y_ien_pos], cfg_reg[z_ien_pos]};
	assign latched_mode = !cfg_reg[latch_pos];
	assign active_high = cfg_reg[polarity_pos];
	assign pin_enable = cfg_reg[pin_en_pos];

	// Bus strobes; a write and a read in one cycle both act
	assign wr_cfg = reg_wr && addr_is(reg_addr, cfg_addr);
	assign wr_ths_low = reg_wr && addr_is(reg_addr, ths_low_addr);
	assign wr_ths_high = reg_wr && addr_is(reg_addr, ths_high_addr);
	// The source register has no write path, so a write there is ignored
	assign src_read = reg_rd && addr_is(reg_addr, src_addr);

	// X axis comparator
	axis_compare cmp_x
	(
		.sample(x_sample),
		.threshold_value(threshold_value),
		.axis_enable(axis_en[2]),
		.pos_hit(pos_hit[2]),
		.neg_hit(neg_hit[2])
	);

	// Y axis comparator
	axis_compare cmp_y
	(
		.sample(y_sample),
		.threshold_value(threshold_value),
		.axis_enable(axis_en[1]),
		.pos_hit(pos_hit[1]),
		.neg_hit(neg_hit[1])
	);

	// Z axis comparator
	axis_compare cmp_z
	(
		.sample(z_sample),
		.threshold_value(threshold_value),
		.axis_enable(axis_en[0]),
		.pos_hit(pos_hit[0]),
		.neg_hit(neg_hit[0])
	);

	// Axis events need an enabled axis; overflow ignores the enables
	assign axis_event = (|pos_hit) || (|neg_hit);
	// Summary covers every kind of event on a valid sample
	assign event_now = sample_valid && (axis_event || range_overflow);

	// Configuration register; reserved bits are stored as written
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			cfg_reg <= cfg_reset;
		else if (wr_cfg)
			cfg_reg <= reg_wdata;
	end

	// Low threshold byte
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			ths_low_reg <= ths_reset;
		else if (wr_ths_low)
			ths_low_reg <= reg_wdata;
	end

	// High threshold byte. The MSB is forced to zero so that a stray bit
	// from the host can never read back or widen the magnitude.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			ths_high_reg <= ths_reset;
		else if (wr_ths_high)
			ths_high_reg <= reg_wdata & ths_high_mask;
	end

	// Next source flags.
	// Latched: flags accumulate until the host reads the source register.
	// Unlatched: each valid sample replaces the flags, reads leave them.
	// A new event in the cycle of a read wins, so no event is ever lost;
	// the cost is that such an event shows only on the following read.
	always_comb
	begin
		src_next = src_reg;
		// Read clear only applies when latching
		if (src_read && latched_mode)
			src_next = src_reset;
		if (sample_valid)
		begin
			// Unlatched mode starts each sample from clean flags
			if (!latched_mode)
				src_next = src_reset;
			src_next[x_pos_pos -: 3] = src_next[x_pos_pos -: 3] | pos_hit;
			src_next[x_neg_pos -: 3] = src_next[x_neg_pos -: 3] | neg_hit;
			src_next[ovf_pos] = src_next[ovf_pos] | range_overflow;
			src_next[int_pos] = src_next[int_pos] | event_now;
		end
	end

	// Source register
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			src_reg <= src_reset;
		else
			src_reg <= src_next;
	end

	// Read mux; unmapped offsets read zero
	always_comb
	begin
		case (reg_addr)
			cfg_addr: rdata_next = cfg_reg;
			src_addr: rdata_next = src_reg; // Value before the read clear
			ths_low_addr: rdata_next = ths_low_reg;
			ths_high_addr: rdata_next = ths_high_reg;
			default: rdata_next = rdata_reset;
		endcase
	end

	// Read data register; holds until the next read strobe
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			reg_rdata <= rdata_reset;
		else if (reg_rd)
			reg_rdata <= rdata_next;
	end

	// Pin level tracks the summary flag of the coming edge, so the pin
	// moves on the same edge as the source register
	assign irq_out_next = to_pin(src_next[int_pos], active_high);

	// Output enable; the pin floats until the host turns it on
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			irq_oe <= 1'b0;
		else
			irq_oe <= pin_enable;
	end

	// Pin level. Reset leaves it at the idle level of the reset polarity,
	// so no false edge follows the release of reset.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			irq_out <= irq_idle_reset;
		else
			irq_out <= irq_out_next;
	end
endmodule // magnetic_threshold_interrupt

// file: dv/mti_checker.sv
`timescale 1ns/1ns
// Port-level checks on register reads and the pin
module mti_checker
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic sample_valid,
	input wire logic range_overflow,
	input wire logic irq_out,
	input wire logic irq_oe
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	unmapped_zero_a: assert property (reg_rd && reg_addr[7:2] != 6'h0c |=> !reg_rdata) else $error("unmapped");
	rdata_holds_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
	high_msb_a: assert property (reg_rd && reg_addr == 8'h33 |=> !reg_rdata[7]) else $error("msb set");
	summary_bit_a: assert property (reg_rd && reg_addr == 8'h31 |=> reg_rdata[0] == |reg_rdata[7:1]) else $error("sum");
	ths_back_a: assert property (reg_wr && reg_addr == 8'h32 ##1 !reg_wr ##1 reg_rd && reg_addr == 8'h32
		|=> reg_rdata == $past(reg_wdata, 3)) else $error("ths");
	oe_cause_a: assert property ($changed(irq_oe) |-> $past(reg_wr) || $past(reg_wr, 2)) else $error("oe");
	irq_cause_a: assert property ($changed(irq_out) |-> $past(sample_valid || reg_rd || reg_wr) || $past(reg_wr, 2))
		else $error("irq");
	ovf_flag_a: assert property (sample_valid && range_overflow ##1 !sample_valid && !reg_rd
		##1 reg_rd && reg_addr == 8'h31 && !sample_valid
		|=> reg_rdata[1:0] == 2'b11) else $error("ovf");
endmodule // mti_checker

// file: dv/host_model.sv
`timescale 1ns/1ns
// Host on the register port; a released bus shows inverted values
module host_model
(
	input wire logic mclk,
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_wdata
);
	initial {reg_addr, reg_wr, reg_rd, reg_wdata} = 18'h0;
	// One strobe cycle, then an idle cycle
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		#10 {reg_addr, reg_wr, reg_rd} = {a, w, !w};
		reg_wdata = (a == 8'h33) ? (d & 8'h7f) : d;
		@(posedge mclk);
		#10 {reg_addr, reg_wr, reg_rd, reg_wdata} = {~a, 2'b00, ~d};
	endtask
endmodule // host_model

// file: dv/magnetic_threshold_interrupt_tb_top.sv
`timescale 1ns/1ns
// Reads are noted in a queue and checked as results land
module magnetic_threshold_interrupt_tb_top;
	logic mclk = 0, rstn = 0, sample_valid = 0, range_overflow = 0, pol, rd_seen = 0;
	wire logic [7:0] reg_addr, reg_wdata;
	wire logic reg_wr, reg_rd;
	logic [7:0] reg_rdata, cfg, exp_q[$];
	logic irq_out, irq_oe;
	logic [15:0] x_sample = 0, y_sample = 0, z_sample = 0, th, v;
	int n_errors = 0, checked = 0;
	always #50 mclk = ~mclk;
	magnetic_threshold_interrupt dut (.*);
	host_model host (.*);
	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		checked++;
		if (seen !== want)
		begin
			n_errors++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.acc(0, a, e);
	endtask
	// Read data shows one edge after the strobe
	always @(posedge mclk)
	begin
		if (rd_seen)
			chk(reg_rdata, exp_q.pop_front());
		rd_seen <= reg_rd;
	end
	task smp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z, input logic o);
		@(posedge mclk);
		#10 {x_sample, y_sample, z_sample, range_overflow, sample_valid} = {x, y, z, o, 1'b1};
		@(posedge mclk);
		#10 sample_valid = 0;
	endtask
	task end_of_test;
		$display("errors %0d checked %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Whole run is under a hundred cycles
	initial
	begin
		#200000 n_errors++;
		end_of_test;
	end
	initial
	begin
		void'($urandom(77));
		repeat (20) @(posedge mclk);
		#10 rstn = 1;
		chk({7'h0, irq_oe}, 8'h00);
		for (int a = 8'h30; a < 8'h34; a++)
			rd(a[7:0], 8'h00);
		host.acc(1, 8'h31, 8'hff);
		rd(8'h31, 8'h00);
		rd(8'h40 + $urandom % 8'hc0, 8'h00);
		th = $urandom_range(16'h7ffe, 1);
		host.acc(1, 8'h32, th[7:0]);
		rd(8'h32, th[7:0]);
		host.acc(1, 8'h33, {1'b1, th[14:8]});
		rd(8'h33, {1'b0, th[14:8]});
		pol = $urandom % 2;
		cfg = {5'b11100, pol, 2'b01};
		host.acc(1, 8'h30, cfg);
		// Each axis once per sign, latched; read clears the pin
		for (int k = 0; k < 6; k++)
		begin
			v = k > 2 ? -(th + 16'h1) : th + 16'h1;
			smp(k % 3 == 0 ? v : 16'h0, k % 3 == 1 ? v : 16'h0, k % 3 == 2 ? v : 16'h0, 0);
			chk({7'h0, irq_out}, {7'h0, pol});
			chk({7'h0, irq_oe}, 8'h01);
			rd(8'h31, 8'h01 | 8'h80 >> (k % 3 + 3 * (k > 2)));
			chk({7'h0, irq_out}, {7'h0, !pol});
		end
		smp(th, -th, th, 1);
		rd(8'h31, 8'h03);
		host.acc(1, 8'h30, 8'h01);
		smp(th + 16'h1, th + 16'h1, th + 16'h1, 0);
		rd(8'h31, 8'h00);
		// Unlatched, X only, pin off: flags follow each sample
		host.acc(1, 8'h30, 8'h82);
		@(posedge mclk);
		#10 chk({7'h0, irq_oe}, 8'h00);
		smp(th + 16'h1, 16'h0, 16'h0, 0);
		rd(8'h31, 8'h81);
		smp(16'h0, 16'h0, 16'h0, 0);
		rd(8'h31, 8'h00);
		repeat (2) @(posedge mclk);
		end_of_test;
	end
endmodule // magnetic_threshold_interrupt_tb_top
bind magnetic_threshold_interrupt mti_checker chk_i (.*);
